// >>> hw/usb_root_port_pkg.sv
package usb_root_port_pkg;

  // Topology
  localparam int NUM_PORTS = 2;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int PIN_W     = 4;
  localparam int TEST_W    = 4;
  localparam int WAKE_W    = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CONFIGURED_FLAG_OFFSET = 8'h60;
  localparam logic [ADDR_W-1:0] PORT0_OFFSET           = 8'h64;
  localparam logic [ADDR_W-1:0] PORT_STRIDE            = 8'h04;

  // Port register field positions
  localparam int BIT_WAKE_LO   = 20; // Connect, disconnect, over-current
  localparam int BIT_WAKE_OC   = 22;
  localparam int BIT_WAKE_DISC = 21;
  localparam int BIT_WAKE_CONN = 20;
  localparam int BIT_TEST_LO   = 16;
  localparam int BIT_OWNER     = 13;
  localparam int BIT_POWER     = 12;
  localparam int BIT_LINE_DP   = 11;
  localparam int BIT_LINE_DM   = 10;
  localparam int BIT_RESET     = 8;
  localparam int BIT_SUSPEND   = 7;
  localparam int BIT_RESUME    = 6;
  localparam int BIT_OC_CHG    = 5;
  localparam int BIT_OC_ACT    = 4;
  localparam int BIT_EN_CHG    = 3;
  localparam int BIT_ENABLED   = 2;
  localparam int BIT_CONN_CHG  = 1;
  localparam int BIT_CONN      = 0;
  localparam int BIT_CFG_FLAG  = 0;

  // Reset values
  localparam logic [TEST_W-1:0] TEST_OFF   = 4'h0;
  localparam logic [WAKE_W-1:0] WAKE_NONE  = 3'h0;
  localparam logic              OWNER_INIT = 1'b1;

  // Pins of one port, as seen from the transceiver
  typedef struct packed {
    logic dp;
    logic dm;
    logic connect;
    logic overcurrent;
  } port_pins_t;

  // Drive and status towards the transceiver and core
  typedef struct packed {
    logic              bus_reset;
    logic              resume;
    logic              eop;
    logic              suspend;
    logic              enabled;
    logic              companion_owned;
    logic              test_active;
    logic [TEST_W-1:0] test_select;
    logic              wake;
  } port_drive_t;

  // Link state, Gray along idle-reset-active-suspend-resume-eop
  typedef enum logic [2:0] {
    LINK_IDLE    = 3'h0,
    LINK_RESET   = 3'h1,
    LINK_ACTIVE  = 3'h3,
    LINK_SUSPEND = 3'h2,
    LINK_RESUME  = 3'h6,
    LINK_EOP     = 3'h7
  } link_state_t;

endpackage : usb_root_port_pkg

// >>> hw/pin_sync3.sv
module pin_sync3
  import usb_root_port_pkg::*;
#(
  parameter int WIDTH = PIN_W
)
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pins in, filtered levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Three-stage chain; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a new level only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_out <= '0;
    else
      sync_out <= (stage2 & stage3) | (sync_out & (stage2 ^ stage3));
  end

endmodule : pin_sync3

// >>> hw/port_events.sv
module port_events
  import usb_root_port_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Filtered port levels
  input  wire port_pins_t        pins,
  input  wire logic              suspended,
  input  wire logic [WAKE_W-1:0] wake_enable,
  // Events, one cycle each
  output logic                   connect_edge,
  output logic                   disconnect,
  output logic                   oc_edge,
  output logic                   j_to_k,
  output logic                   wake
);

  port_pins_t prev;

  // Previous levels for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev <= '0;
    else
      prev <= pins;
  end

  // J is dp high dm low, K the reverse
  always_comb
  begin
    connect_edge = pins.connect ^ prev.connect;
    disconnect   = prev.connect & ~pins.connect;
    oc_edge      = pins.overcurrent ^ prev.overcurrent;
    j_to_k       = prev.dp & ~prev.dm & ~pins.dp & pins.dm;
    wake         = suspended & (
      (wake_enable[BIT_WAKE_OC - BIT_WAKE_LO] & pins.overcurrent
        & ~prev.overcurrent) |
      (wake_enable[BIT_WAKE_DISC - BIT_WAKE_LO] & disconnect) |
      (wake_enable[BIT_WAKE_CONN - BIT_WAKE_LO] & pins.connect
        & ~prev.connect));
  end

endmodule : port_events

// >>> hw/usb2_root_port_status_control.sv
// Function
// - Over-current wake enable bit 22 makes over-current a wake event.
// - Disconnect wake enable bit 21 makes a disconnect a wake event.
// - Connect wake enable bit 20 makes a connect a wake event.
// - Test field bits 19-16 selects test; zero means no test mode.
// - Owner bit 13 clears on configured rise, held one while unconfigured.
// - Port power bit 12 always reads one.
// - Bit 11 shows D+ level, bit 10 shows D- level.
// - Writing one to bit 8 starts bus reset; zero ends it.
// - Writing one to bit 7 suspends; writing zero does nothing.
// - Suspend clears on software resume fall or port reset set.
// - Setting force-resume bit 6 while suspended drives resume signalling.
// - J-to-K while suspended sets force-resume in hardware.
// - Clearing force-resume finishes the resume sequence.
// - Over-current change bit 5 sets on any change; write one clears.
// - Bit 4 reads one while over-current is present.
// - Enable change bit 3 sets only on EOF2 disable; write one clears.
// - Only reset-and-enable can set enable bit 2; writes cannot.
// - Enable clears on EOF2 fault, disconnect or software writing zero.
// - Connect change bit 1 sets on connect change; write one clears.
// - Bit 0 reflects current connection.
// - Reserved bits read zero.
// - Configured flag routes all ports to this controller.
// - Two identical port registers, port 1 at 68h.
module usb2_root_port_status_control
  import usb_root_port_pkg::*;
(
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [DATA_W-1:0]           pwdata,
  output logic                             pready,
  output logic      [DATA_W-1:0]           prdata,
  output logic                             pslverr,
  // Port pins, asynchronous
  input  wire port_pins_t [NUM_PORTS-1:0]  port_pins,
  // Frame timer, same clock
  input  wire logic       [NUM_PORTS-1:0]  eof2_fault,
  // Port drive and status
  output port_drive_t     [NUM_PORTS-1:0]  port_drive,
  output logic                             host_configured,
  output logic            [NUM_PORTS-1:0]  port_change
);

  // Address hit, used for every register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] offset);
    addr_hit = (addr == offset);
  endfunction : addr_hit
  function automatic logic [ADDR_W-1:0] port_offset(input int idx);
    port_offset = PORT0_OFFSET + ADDR_W'(idx) * PORT_STRIDE;
  endfunction : port_offset
  port_pins_t [NUM_PORTS-1:0] pins_sync;
  logic                       access;
  logic                       wr;
  logic                       cfg_prev;
  logic                       cfg_rise;
  logic [DATA_W-1:0]          next_rdata;
  logic                       next_err;
  logic [DATA_W-1:0]          port_word [NUM_PORTS];
  // All pins of all ports through one filtered chain
  pin_sync3 #(
    .WIDTH (NUM_PORTS * PIN_W)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (port_pins),
    .sync_out (pins_sync)
  );
  // Writes land at the edge that samples pready high
  assign access   = psel & penable & pready;
  assign wr       = access & pwrite;
  assign cfg_rise = host_configured & ~cfg_prev;
  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end
  // Read data and error captured with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready)
    begin
      prdata  <= pwrite ? '0 : next_rdata;
      pslverr <= next_err;
    end
  end
  // Read mux; unmapped addresses answer with an error and zero
  always_comb
  begin
    next_rdata = '0;
    next_err   = 1'b1;
    if (addr_hit(paddr, CONFIGURED_FLAG_OFFSET))
    begin
      next_rdata[BIT_CFG_FLAG] = host_configured;
      next_err                 = 1'b0;
    end
    for (int k = 0; k < NUM_PORTS; k++)
    begin
      if (addr_hit(paddr, port_offset(k)))
      begin
        next_rdata = port_word[k];
        next_err   = 1'b0;
      end
    end
  end
  // Configured flag; reset leaves all ports with the companion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_configured <= 1'b0;
      cfg_prev        <= 1'b0;
    end
    else
    begin
      if (wr && addr_hit(paddr, CONFIGURED_FLAG_OFFSET))
        host_configured <= pwdata[BIT_CFG_FLAG];
      cfg_prev <= host_configured;
    end
  end

  for (genvar i = 0; i < NUM_PORTS; i++)
  begin : g_port
    logic              port_wr;
    logic [WAKE_W-1:0] wake_enable;
    logic [TEST_W-1:0] test_control;
    logic              owner;
    logic              reset_bit;
    logic              suspend_bit;
    logic              resume_bit;
    logic              oc_change;
    logic              enable_change;
    logic              enabled;
    logic              connect_change;
    logic              connect_edge;
    logic              disconnect;
    logic              oc_edge;
    logic              j_to_k;
    logic              wake;
    logic              hw_resume;
    logic              sw_resume_fall;
    logic              reset_start;
    logic              reset_end;
    logic              eof2_disable;
    link_state_t       state;
    link_state_t       next_state;
    port_drive_t       drive;
    assign port_wr        = wr && addr_hit(paddr, port_offset(i));
    assign hw_resume      = j_to_k & suspend_bit;
    assign sw_resume_fall = port_wr & resume_bit & ~pwdata[BIT_RESUME]
                            & ~hw_resume;
    assign reset_start    = port_wr & pwdata[BIT_RESET];
    assign reset_end      = port_wr & reset_bit & ~pwdata[BIT_RESET];
    assign eof2_disable   = eof2_fault[i] & enabled;
    port_events u_events (
      .pclk         (pclk),
      .presetn      (presetn),
      .pins         (pins_sync[i]),
      .suspended    (suspend_bit),
      .wake_enable  (wake_enable),
      .connect_edge (connect_edge),
      .disconnect   (disconnect),
      .oc_edge      (oc_edge),
      .j_to_k       (j_to_k),
      .wake         (wake)
    );
    // Plain read/write control fields
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        wake_enable  <= WAKE_NONE;
        test_control <= TEST_OFF;
      end
      else if (port_wr)
      begin
        wake_enable  <= pwdata[BIT_WAKE_LO +: WAKE_W];
        test_control <= pwdata[BIT_TEST_LO +: TEST_W];
      end
    end
    // Ownership follows the configured flag before any write
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        owner <= OWNER_INIT;
      else if (!host_configured)
        owner <= 1'b1;
      else if (cfg_rise)
        owner <= 1'b0;
      else if (port_wr)
        owner <= pwdata[BIT_OWNER];
    end
    // Port reset is timed entirely by software
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        reset_bit <= 1'b0;
      else if (port_wr)
        reset_bit <= pwdata[BIT_RESET];
    end
    // Suspend: write one sets, write zero ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        suspend_bit <= 1'b0;
      else if (sw_resume_fall || reset_start)
        suspend_bit <= 1'b0;
      else if (port_wr && pwdata[BIT_SUSPEND])
        suspend_bit <= 1'b1;
    end
    // Force resume; a remote wake beats a software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        resume_bit <= 1'b0;
      else if (hw_resume)
        resume_bit <= 1'b1;
      else if (port_wr)
        resume_bit <= pwdata[BIT_RESUME];
    end
    // Enable: only the reset-and-enable path may set it
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        enabled <= 1'b0;
      else if (eof2_disable || disconnect)
        enabled <= 1'b0;
      else if (port_wr && !pwdata[BIT_ENABLED])
        enabled <= 1'b0;
      else if (reset_end && pins_sync[i].connect)
        enabled <= 1'b1;
    end
    // Change flags; a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        oc_change      <= 1'b0;
        enable_change  <= 1'b0;
        connect_change <= 1'b0;
      end
      else
      begin
        if (oc_edge)
          oc_change <= 1'b1;
        else if (port_wr && pwdata[BIT_OC_CHG])
          oc_change <= 1'b0;
        if (eof2_disable)
          enable_change <= 1'b1;
        else if (port_wr && pwdata[BIT_EN_CHG])
          enable_change <= 1'b0;
        if (connect_edge)
          connect_change <= 1'b1;
        else if (port_wr && pwdata[BIT_CONN_CHG])
          connect_change <= 1'b0;
      end
    end
    // Link sequencing from the control bits
    always_comb
    begin
      next_state = state;
      case (state)
        LINK_IDLE:
          if (reset_bit)
            next_state = LINK_RESET;
        LINK_RESET:
          if (!reset_bit)
            next_state = enabled ? LINK_ACTIVE : LINK_IDLE;
        LINK_ACTIVE:
          if (reset_bit)
            next_state = LINK_RESET;
          else if (!enabled)
            next_state = LINK_IDLE;
          else if (suspend_bit)
            next_state = LINK_SUSPEND;
        LINK_SUSPEND:
          if (reset_bit)
            next_state = LINK_RESET;
          else if (resume_bit)
            next_state = LINK_RESUME;
          else if (!enabled)
            next_state = LINK_IDLE;
        LINK_RESUME:
          if (reset_bit)
            next_state = LINK_RESET;
          else if (!resume_bit)
            next_state = LINK_EOP;
        LINK_EOP:
          next_state = LINK_ACTIVE;
        default:
          next_state = LINK_IDLE;
      endcase
    end
    // State register, idle after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        state <= LINK_IDLE;
      else
        state <= next_state;
    end

    // Drive outputs registered; link signals decoded from the next state
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        drive <= '0;
      else
      begin
        drive.bus_reset       <= (next_state == LINK_RESET);
        drive.resume          <= (next_state == LINK_RESUME);
        drive.eop             <= (next_state == LINK_EOP);
        drive.suspend         <= (next_state == LINK_SUSPEND);
        drive.enabled         <= enabled;
        drive.companion_owned <= owner;
        drive.test_active     <= (test_control != TEST_OFF);
        drive.test_select     <= test_control;
        drive.wake            <= wake;
      end
    end
    // Change summary stays up until every flag is cleared
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        port_change[i] <= 1'b0;
      else
        port_change[i] <= oc_change | enable_change | connect_change;
    end
    // Register image; reserved bits stay zero
    always_comb
    begin
      port_word[i]                        = '0;
      port_word[i][BIT_WAKE_LO +: WAKE_W] = wake_enable;
      port_word[i][BIT_TEST_LO +: TEST_W] = test_control;
      port_word[i][BIT_OWNER]             = owner;
      port_word[i][BIT_POWER]             = 1'b1;
      port_word[i][BIT_LINE_DP]           = pins_sync[i].dp;
      port_word[i][BIT_LINE_DM]           = pins_sync[i].dm;
      port_word[i][BIT_RESET]             = reset_bit;
      port_word[i][BIT_SUSPEND]           = suspend_bit;
      port_word[i][BIT_RESUME]            = resume_bit;
      port_word[i][BIT_OC_CHG]            = oc_change;
      port_word[i][BIT_OC_ACT]            = pins_sync[i].overcurrent;
      port_word[i][BIT_EN_CHG]            = enable_change;
      port_word[i][BIT_ENABLED]           = enabled;
      port_word[i][BIT_CONN_CHG]          = connect_change;
      port_word[i][BIT_CONN]              = pins_sync[i].connect;
    end

    assign port_drive[i] = drive;
  end

endmodule : usb2_root_port_status_control

// >>> tb/usb_root_port_properties.sv
module usb_root_port_checker
  import usb_root_port_pkg::*;
(
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ADDR_W-1:0]           paddr,
  input wire logic [DATA_W-1:0]           pwdata,
  input wire logic                        pready,
  input wire logic [DATA_W-1:0]           prdata,
  input wire logic                        pslverr,
  // Port side
  input wire logic [NUM_PORTS-1:0]        eof2_fault,
  input wire port_drive_t [NUM_PORTS-1:0] port_drive,
  input wire logic                        host_configured,
  input wire logic [NUM_PORTS-1:0]        port_change
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Completed port 0 accesses; any good port read
  logic wr0;
  logic rd0;
  logic rdp;
  assign wr0 = psel && penable && pready && pwrite && paddr == PORT0_OFFSET;
  assign rd0 = psel && penable && pready && !pwrite && paddr == PORT0_OFFSET;
  assign rdp = pready && !pwrite && !pslverr
               && paddr != CONFIGURED_FLAG_OFFSET;

  // Port 0 only, but reserved and power checks cover any port read; port 1 is the same logic
  chk_reserved_zero: assert property (rdp |-> prdata[31:23] == 9'h0
    && prdata[15:14] == 2'h0 && !prdata[9]) else $error("reserved set");
  chk_power_on: assert property (rdp |-> prdata[BIT_POWER])
    else $error("power bit low");
  chk_owner_held: assert property (rd0 && !host_configured
    |-> prdata[BIT_OWNER]) else $error("owner low while unconfigured");
  chk_enable_origin: assert property ($rose(port_drive[0].enabled)
    |-> $past(port_drive[0].bus_reset)) else $error("enable without reset");
  chk_fault_disable: assert property (eof2_fault[0]
    && port_drive[0].enabled |-> ##[1:3] !port_drive[0].enabled)
    else $error("enabled after fault");
  chk_bus_reset: assert property (wr0 && pwdata[BIT_RESET]
    |-> ##[1:3] port_drive[0].bus_reset) else $error("no bus reset");
  chk_reset_unsuspend: assert property (wr0 && pwdata[BIT_RESET]
    |-> ##[1:3] !port_drive[0].suspend) else $error("suspend kept");
  chk_resume_drive: assert property (wr0 && pwdata[BIT_RESUME]
    && port_drive[0].suspend |-> ##[1:3] port_drive[0].resume)
    else $error("no resume drive");
  chk_resume_finish: assert property (wr0 && !pwdata[BIT_RESUME]
    && port_drive[0].resume |-> ##[1:3] port_drive[0].eop)
    else $error("resume ended without eop");
  chk_test_select: assert property (port_drive[0].test_active
    == (port_drive[0].test_select != TEST_OFF)) else $error("test mismatch");
  chk_change_flag: assert property (rd0 && (prdata[BIT_OC_CHG]
    || prdata[BIT_EN_CHG] || prdata[BIT_CONN_CHG]) |-> ##[0:2] port_change[0])
    else $error("flag without port change");
endmodule : usb_root_port_checker

bind usb2_root_port_status_control usb_root_port_checker u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .eof2_fault, .port_drive, .host_configured,
  .port_change
);

// >>> tb/usb_device_model.sv
module usb_device_model
  import usb_root_port_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // Bench commands
  input  wire logic        attach,
  input  wire logic        overcurrent,
  input  wire logic        remote_k,
  // Cable
  input  wire port_drive_t drive,
  output port_pins_t       pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Host drive wins; pull-downs give SE0 when nothing is attached
  always @(posedge pclk)
  begin
    pins.connect     <= attach;
    pins.overcurrent <= overcurrent;
    if (drive.bus_reset || !attach)
      {pins.dp, pins.dm} <= 2'b00;
    else if (drive.resume || remote_k)
      {pins.dp, pins.dm} <= 2'b01; // K state
    else
      {pins.dp, pins.dm} <= 2'b10; // J idle
  end
endmodule : usb_device_model

// >>> tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_root_port_pkg::*;

  // Design ports and device commands
  logic                            pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0]               paddr;
  logic [DATA_W-1:0]               pwdata, prdata;
  logic                            pready, pslverr, host_configured;
  wire port_pins_t [NUM_PORTS-1:0] port_pins;
  port_drive_t [NUM_PORTS-1:0]     port_drive;
  logic [NUM_PORTS-1:0]            eof2_fault, port_change, attach, ocv, kdrv;
  // Reference model, one entry a port
  int err_count, check_count, cfg, n;
  int wk[2], tst[2], own[2], rst[2], sus[2], res[2];
  int occ[2], oc[2], enc[2], en[2], cc[2], con[2], wakes[2];

  `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    err_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end

  usb2_root_port_status_control u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .port_pins, .eof2_fault, .port_drive,
    .host_configured, .port_change);

  for (genvar i = 0; i < NUM_PORTS; i++)
  begin : g_dev
    usb_device_model u_dev (.pclk, .attach(attach[i]), .overcurrent(ocv[i]),
      .remote_k(kdrv[i]), .drive(port_drive[i]), .pins(port_pins[i]));
  end

  // 200 MHz
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Wake pulses last one cycle, so count them as they pass
  always @(posedge pclk)
    for (int i = 0; i < NUM_PORTS; i++)
      if (port_drive[i].wake === 1'b1)
        wakes[i]++;

  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // One APB transfer; held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 40);
    if (k >= 40)
    begin
      err_count++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Expected port word
  function automatic logic [31:0] exp_reg(int p);
    logic [1:0] ln;
    ln = (rst[p] || !attach[p]) ? 2'b00 : (res[p] || kdrv[p]) ? 2'b01 : 2'b10;
    return {9'h0, 3'(wk[p]), 4'(tst[p]), 2'h0, own[p][0], 1'b1, ln, 1'b0,
            rst[p][0], sus[p][0], res[p][0], occ[p][0], oc[p][0], enc[p][0],
            en[p][0], cc[p][0], con[p][0]};
  endfunction : exp_reg

  // Writable bits as they stand, change flags left at zero
  function automatic logic [31:0] rw(int p);
    return exp_reg(p) & 32'h007f21c4;
  endfunction : rw

  task automatic settle();
    repeat (10) @(posedge pclk);
  endtask : settle

  task automatic chk_port(input int p);
    logic [31:0] q;
    logic        e;
    settle();
    apb(PORT0_OFFSET + 8'(4 * p), 1'b0, '0, q, e);
    `CHK(q, exp_reg(p))
    `CHK(port_change[p], 1'(cc[p] | enc[p] | occ[p]))
    `CHK(port_drive[p].companion_owned, 1'(own[p]))
    `CHK(port_drive[p].enabled, 1'(en[p]))
  endtask : chk_port

  // Port write, mirrored into the model
  task automatic pwr(input int p, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(PORT0_OFFSET + 8'(4 * p), 1'b1, d, q, e);
    wk[p] = d[22:20];
    tst[p] = d[19:16];
    if (cfg != 0) own[p] = d[13];
    if (d[1]) cc[p] = 0;
    if (d[3]) enc[p] = 0;
    if (d[5]) occ[p] = 0;
    if (!d[2]) en[p] = 0;
    if (d[8])
    begin
      rst[p] = 1;
      sus[p] = 0;
    end
    else if (rst[p] != 0)
    begin
      rst[p] = 0;
      en[p] = con[p] & d[2];
    end
    if (d[7] && !d[8]) sus[p] = 1;
    if (d[6]) res[p] = 1;
    else if (res[p] != 0)
    begin
      res[p] = 0;
      sus[p] = 0;
    end
  endtask : pwr

  task automatic cfg_wr(input int v);
    logic [31:0] q;
    logic        e;
    apb(CONFIGURED_FLAG_OFFSET, 1'b1, 32'(v), q, e);
    if (v == 0) own = '{1, 1};
    else if (cfg == 0) own = '{0, 0};
    cfg = v;
    apb(CONFIGURED_FLAG_OFFSET, 1'b0, '0, q, e);
    `CHK(q, 32'(v))
    `CHK(host_configured, 1'(v))
  endtask : cfg_wr

  // Device side changes; a change of level is a change event
  task automatic set_pins(input int p, input logic a, input logic o);
    @(posedge pclk);
    if (a !== attach[p])
    begin
      cc[p] = 1;
      con[p] = a;
      if (!a) en[p] = 0;
    end
    if (o !== ocv[p])
    begin
      occ[p] = 1;
      oc[p] = o;
    end
    attach[p] <= a;
    ocv[p] <= o;
    settle();
  endtask : set_pins

  initial
  begin
    logic [31:0] q;
    logic        e;
    void'($urandom(32'h8e4b));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {eof2_fault, attach, ocv, kdrv} = '0;
    own = '{1, 1};
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_port(0);
    chk_port(1);
    apb(8'h6c, 1'b0, '0, q, e);
    `CHK({e, q}, 33'h1_0000_0000)
    apb(8'h65, 1'b1, 32'h0040_0000, q, e);
    `CHK(e, 1'b1)
    // Every test code on both ports, random reserved bits, ends at zero
    for (int i = 0; i < 32; i++)
    begin
      n = (i / 2 + 1) % 16;
      pwr(i % 2, ($urandom & ~32'h000f_01c4) | (32'(n) << 16));
      chk_port(i % 2);
      `CHK(port_drive[i % 2].test_select, 4'(n))
      `CHK(port_drive[i % 2].test_active, n != 0)
    end
    cfg_wr(1);
    pwr(0, 32'h2000);
    chk_port(0);
    cfg_wr(0);
    chk_port(0);
    cfg_wr(1);
    chk_port(0);
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      set_pins(p, 1'b1, 1'b0);
      chk_port(p);
      pwr(p, rw(p) | 32'h2);
      chk_port(p);
      pwr(p, rw(p) | 32'h104);
      chk_port(p);
      `CHK(port_drive[p].bus_reset, 1'b1)
      pwr(p, rw(p) & ~32'h100 | 32'h4);
      chk_port(p);
      pwr(p, rw(p) & ~32'h700000 | 32'h400080);
      pwr(p, rw(p) & ~32'h80);
      chk_port(p);
      n = wakes[p];
      set_pins(p, 1'b1, 1'b1);
      chk_port(p);
      set_pins(p, 1'b1, 1'b0);
      `CHK(wakes[p], n + 1)
      kdrv[p] <= 1'b1;
      res[p] = 1;
      settle();
      chk_port(p);
      kdrv[p] <= 1'b0;
      pwr(p, rw(p) & ~32'h40 | 32'h20);
      chk_port(p);
      pwr(p, rw(p) | 32'h80);
      pwr(p, rw(p) | 32'h40);
      settle();
      `CHK(port_drive[p].resume, 1'b1)
      pwr(p, rw(p) & ~32'h40);
      chk_port(p);
      eof2_fault[p] <= 1'b1;
      @(posedge pclk);
      eof2_fault[p] <= 1'b0;
      en[p] = 0;
      enc[p] = 1;
      settle();
      chk_port(p);
      pwr(p, rw(p) | 32'h8);
      pwr(p, rw(p) | 32'h104);
      pwr(p, rw(p) & ~32'h100 | 32'h4);
      pwr(p, rw(p) | 32'h80);
      pwr(p, rw(p) | 32'h100);
      chk_port(p);
      pwr(p, rw(p) & ~32'h100 | 32'h4);
      pwr(p, rw(p) & ~32'h4);
      chk_port(p);
      set_pins(p, 1'b0, 1'b0);
      chk_port(p);
    end
    results();
  end
endmodule : tb_top
